// ==== codec_cmd_pkg.sv ====
/*
  Shared constants for the host command interpreter and its coefficient store.
  Assumes one 10 MHz clock domain; nothing here holds state.
*/
package codec_cmd_pkg;
  // Byte and word geometry
  localparam int BYTE_W    = 8;
  localparam int ADDR_W    = 5;
  localparam int WORD_W    = 14;
  localparam int XFER_W    = 16;
  localparam int DROP_BITS = 2;
  localparam int COUNT_W   = 4;
  // Command byte layout
  localparam int CMD_RW_BIT  = 7;
  localparam int CMD_TYPE_HI = 6;
  localparam int CMD_TYPE_LO = 5;
  localparam logic [1:0] TYPE_LOCAL  = 2'h0;
  localparam logic [1:0] TYPE_GLOBAL = 2'h1;
  localparam logic [1:0] TYPE_BAD    = 2'h2;
  localparam logic [1:0] TYPE_COEFF  = 2'h3;
  // Register walk: low address bits give the number of extra registers
  localparam int WALK_HI = 1;
  // Coefficient store
  localparam int CHANNELS    = 4;
  localparam int BLOCK_W     = 3;
  localparam int WORD_SEL_W  = 3;
  localparam int COEFF_AW    = 6;
  localparam int COEFF_WORDS = 40;
  localparam int BLOCK_COUNT = 5;
  localparam int TONE_AW     = 2;
  localparam int TONE_WORDS  = 4;
  localparam logic [COEFF_AW-1:0] TONE_FIRST = 6'h14;
  localparam logic [COUNT_W-1:0]  BLOCK_WORDS = 4'h8;
  // Global registers handled here
  localparam logic [ADDR_W-1:0] ADDR_VERSION   = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_CH_ENABLE = 5'h05;
  localparam logic [BYTE_W-1:0] CH_ENABLE_RESET = 8'h02;
  localparam int CE_LO  = 4;
  localparam int SEL_HI = 3;
  // Arbitrary identification values, not tied to any product
  localparam logic [BYTE_W-1:0] ID_CODE_DEFAULT = 8'h5a;
  localparam logic [BYTE_W-1:0] VERSION_DEFAULT = 8'h01;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_CMD   = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_READ  = 5'b01000,
    ST_HOLD  = 5'b10000
  } state_t;
endpackage

// ==== coeff_word_ram.sv ====
/*
  Small coefficient word memory with one write port and a registered read.
  Assumes the caller keeps addresses inside DEPTH; contents survive reset.
*/
`timescale 1ns/1ps
module coeff_word_ram #(
  parameter int DEPTH = 8,
  parameter int AW    = 3,
  parameter int DW    = 14
) (
  input  wire logic          clock,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  // No reset: coefficients must outlive every kind of reset
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data always from a flop, one cycle behind the address
  always_ff @(posedge clock) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// ==== host_byte_model.sv ====
/*
  Host side model: frames bytes onto the command port and takes replies.
  Assumes every task is entered at a falling clock edge.
*/
`timescale 1ns/1ps
module host_byte_model (
  input  wire logic       clock,
  output logic            cs_n,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            tx_take,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid
);
  // Idle pins from time zero
  initial begin
    cs_n = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_take = 1'b0;
  end
  // Four cycles let the cs sync settle before the command byte
  task automatic open_frame();
    cs_n = 1'b0;
    repeat (4) @(negedge clock);
  endtask
  // Data shows the inverse between bytes, so stale values never pass
  task automatic send(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_data = b;
    @(negedge clock);
    rx_valid = 1'b0;
    rx_data = ~b;
    @(negedge clock);
  endtask
  // Lag makes a slow host; x comes back when no byte turns up
  task automatic take(input int lag, output logic [7:0] b);
    repeat (lag) @(negedge clock);
    for (int i = 0; i < 20 && tx_valid !== 1'b1; i++) @(negedge clock);
    b = (tx_valid === 1'b1) ? tx_data : 8'hxx;
    tx_take = 1'b1;
    @(negedge clock);
    tx_take = 1'b0;
    @(negedge clock);
  endtask
  // Gap long enough for the next frame
  task automatic close_frame();
    cs_n = 1'b1;
    repeat (4) @(negedge clock);
  endtask
endmodule

// ==== host_command_port.sv ====
/*
  Host command interpreter: decodes command bytes, walks registers and
  coefficient blocks, and returns read bytes behind an identification byte.
  Assumes a byte shifter on the same clock delivers rx bytes and takes tx
  bytes; chip select is a raw pin and is synchronised here.
*/
// Functional notes
// - Global commands need no channel selection.
// - Global walks descend like local walks; chip select rise ends them.
// - Coefficient store is 40 words, 5 blocks of 8, 14 bits each.
// - Block 1 words 0-7 impedance match; block 2 words 8-15 echo cancel.
// - Block 3 words 16-19 scaling gain, words 20-23 tone.
// - Block 4 words 24-30 transmit response, word 31 transmit gain.
// - Block 5 words 32-38 receive response, word 39 receive gain.
// - Non-tone words shared by all channels; tone words stored per channel.
// - Written word arrives as two bytes MSB first; two lowest bits dropped.
// - Read word goes out as 16 bits MSB first; lowest two meaningless.
// - Coefficient address selects block; words stepped highest to lowest, all 8.
// - Chip select rise aborts current word; completed words kept.
// - Local write at address 1 takes two bytes: register two, then one.
// - Local read at address 1 returns ID, register two, register one.
// - Global write 1010,0000 addresses version register, one data byte.
// - Global read 0010,0000 returns ID then version register.
// - Coefficient write 1110,0000 takes 16 bytes, word 8 down to 1.
// - Coefficient write with address 00010 selects block 3, enabled channel tones.
// - Bit 7 write/read; bits 6:5 local, global, coefficient; 10 refused.
// - Channel-enable bits map to channels 4 down to 1, each a target.
// - Every read first sends the identification byte.
`timescale 1ns/1ps
module host_command_port
  import codec_cmd_pkg::*;
#(
  parameter logic [codec_cmd_pkg::BYTE_W-1:0] ID_CODE = codec_cmd_pkg::ID_CODE_DEFAULT,
  parameter logic [codec_cmd_pkg::BYTE_W-1:0] VERSION = codec_cmd_pkg::VERSION_DEFAULT
) (
  input  wire logic                                   clock,
  input  wire logic                                   arst_n,
  input  wire logic                                   cs_n,
  input  wire logic                                   rx_valid,
  input  wire logic [codec_cmd_pkg::BYTE_W-1:0]       rx_data,
  input  wire logic                                   tx_take,
  output logic      [codec_cmd_pkg::BYTE_W-1:0]       tx_data,
  output logic                                        tx_valid,
  output logic                                        reg_wr,
  output logic                                        reg_wr_global,
  output logic      [codec_cmd_pkg::ADDR_W-1:0]       reg_wr_addr,
  output logic      [codec_cmd_pkg::BYTE_W-1:0]       reg_wdata,
  output logic                                        reg_rd,
  output logic                                        reg_rd_global,
  output logic      [codec_cmd_pkg::ADDR_W-1:0]       reg_rd_addr,
  input  wire logic [codec_cmd_pkg::BYTE_W-1:0]       reg_rdata,
  output logic      [codec_cmd_pkg::CHANNELS-1:0]     chan_enable,
  output logic      [codec_cmd_pkg::SEL_HI:0]         clock_select
);
  import codec_cmd_pkg::*;

  state_t                state_reg;
  logic                  cs_meta_reg;
  logic                  cs_sync_reg;
  logic                  is_write_reg;
  logic [1:0]            type_reg;
  logic [ADDR_W-1:0]     addr_reg;
  logic [BLOCK_W-1:0]    block_reg;
  logic [COUNT_W-1:0]    left_reg;
  logic                  half_reg;
  logic [BYTE_W-1:0]     hi_byte_reg;
  logic [BYTE_W-1:0]     ch_enable_reg;
  logic [BYTE_W-1:0]     tx_data_reg;
  logic                  tx_valid_reg;
  logic                  reg_wr_reg;
  logic                  reg_wr_global_reg;
  logic [ADDR_W-1:0]     reg_wr_addr_reg;
  logic [BYTE_W-1:0]     reg_wdata_reg;

  logic                  rx_take;
  logic                  tx_step;
  logic                  is_coeff;
  logic                  is_global;
  logic                  walk_left;
  logic                  cmd_bad;
  logic [WORD_SEL_W-1:0] word_off;
  logic [COEFF_AW-1:0]   coeff_word;
  logic                  is_tone;
  logic [TONE_AW-1:0]    tone_idx;
  logic                  wr_word;
  logic [WORD_W-1:0]     wr_word_data;
  logic [XFER_W-1:0]     wr_pair;
  logic [WORD_W-1:0]     shared_rd;
  logic [WORD_W-1:0]     tone_rd [CHANNELS];
  logic [WORD_W-1:0]     rd_word;
  logic [XFER_W-1:0]     rd_bytes;
  logic [BYTE_W-1:0]     reg_value;
  logic [CHANNELS-1:0]   ce_bits;
  logic [1:0]            read_chan;

  // Lowest enabled channel; reads never address several channels at once
  function automatic logic [1:0] first_channel(input logic [CHANNELS-1:0] ce);
    logic [1:0] pick;
    pick = 2'h0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (ce[i]) begin
        pick = 2'(i);
      end
    end
    return pick;
  endfunction

  // Two flops on the chip select pin before anything looks at it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
    end else begin
      cs_meta_reg <= cs_n;
      cs_sync_reg <= cs_meta_reg;
    end
  end

  // Bytes count only inside a frame
  assign rx_take   = rx_valid && !cs_sync_reg;
  assign tx_step   = tx_take && tx_valid_reg && state_reg == ST_READ;
  assign is_coeff  = type_reg == TYPE_COEFF;
  assign is_global = type_reg == TYPE_GLOBAL;
  assign walk_left = left_reg != '0;
  assign cmd_bad   = rx_data[CMD_TYPE_HI:CMD_TYPE_LO] == TYPE_BAD;

  // Current coefficient word: block base plus countdown offset
  assign word_off   = WORD_SEL_W'(left_reg - 1'b1);
  assign coeff_word = {block_reg, word_off};
  assign is_tone    = coeff_word >= TONE_FIRST
                      && coeff_word < TONE_FIRST + COEFF_AW'(TONE_WORDS);
  assign tone_idx   = TONE_AW'(coeff_word - TONE_FIRST);
  assign ce_bits    = ch_enable_reg[BYTE_W-1:CE_LO];
  assign read_chan  = first_channel(ce_bits);

  // A word is committed only when its low byte lands
  assign wr_word      = state_reg == ST_WRITE && rx_take && is_coeff && half_reg;
  assign wr_pair      = {hi_byte_reg, rx_data};
  assign wr_word_data = wr_pair[XFER_W-1:DROP_BITS];

  // Shared copy of filter and gain words
  coeff_word_ram #(
    .DEPTH (COEFF_WORDS),
    .AW    (COEFF_AW),
    .DW    (WORD_W)
  ) shared_ram (
    .clock   (clock),
    .wr_en   (wr_word && !is_tone),
    .wr_addr (coeff_word),
    .wr_data (wr_word_data),
    .rd_addr (coeff_word),
    .rd_data (shared_rd)
  );

  // Tone words kept once per channel; writes reach every enabled channel
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_tone
    coeff_word_ram #(
      .DEPTH (TONE_WORDS),
      .AW    (TONE_AW),
      .DW    (WORD_W)
    ) tone_ram (
      .clock   (clock),
      .wr_en   (wr_word && is_tone && ce_bits[ch]),
      .wr_addr (tone_idx),
      .wr_data (wr_word_data),
      .rd_addr (tone_idx),
      .rd_data (tone_rd[ch])
    );
  end

  // Read word padded back to 16 bits; low two bits carry nothing
  assign rd_word  = is_tone ? tone_rd[read_chan] : shared_rd;
  assign rd_bytes = {rd_word, {DROP_BITS{1'b0}}};

  // Register read source; version and channel enable live here
  always_comb begin
    reg_value = reg_rdata;
    if (is_global && addr_reg == ADDR_VERSION) begin
      reg_value = VERSION;
    end else if (is_global && addr_reg == ADDR_CH_ENABLE) begin
      reg_value = ch_enable_reg;
    end
  end

  // Sequencer: command, then write walk or read walk, abort on select rise
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else if (cs_sync_reg) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_CMD;
        end
        ST_CMD: begin
          if (rx_take) begin
            if (cmd_bad) begin
              state_reg <= ST_HOLD;
            end else if (rx_data[CMD_TYPE_HI:CMD_TYPE_LO] == TYPE_COEFF
                         && rx_data[BLOCK_W-1:0] >= BLOCK_W'(BLOCK_COUNT)) begin
              state_reg <= ST_HOLD;
            end else if (rx_data[ADDR_W-1:BLOCK_W] != '0
                         && rx_data[CMD_TYPE_HI:CMD_TYPE_LO] == TYPE_COEFF) begin
              state_reg <= ST_HOLD;
            end else if (rx_data[CMD_RW_BIT]) begin
              state_reg <= ST_WRITE;
            end else begin
              state_reg <= ST_READ;
            end
          end
        end
        ST_WRITE: begin
          if (rx_take && left_reg == 4'h1 && (!is_coeff || half_reg)) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_READ: begin
          if (tx_step && !walk_left && !half_reg) begin
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          state_reg <= ST_HOLD; // Extra bytes ignored until deselect
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Command fields and walk counters
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      is_write_reg <= 1'b0;
      type_reg     <= TYPE_LOCAL;
      addr_reg     <= '0;
      block_reg    <= '0;
      left_reg     <= '0;
      half_reg     <= 1'b0;
      hi_byte_reg  <= '0;
    end else if (cs_sync_reg) begin
      half_reg <= 1'b0;
      left_reg <= '0;
    end else if (state_reg == ST_CMD && rx_take) begin
      is_write_reg <= rx_data[CMD_RW_BIT];
      type_reg     <= rx_data[CMD_TYPE_HI:CMD_TYPE_LO];
      addr_reg     <= rx_data[ADDR_W-1:0];
      block_reg    <= rx_data[BLOCK_W-1:0];
      half_reg     <= 1'b0;
      if (rx_data[CMD_TYPE_HI:CMD_TYPE_LO] == TYPE_COEFF) begin
        left_reg <= BLOCK_WORDS;
      end else begin
        left_reg <= COUNT_W'(rx_data[WALK_HI:0]) + 1'b1;
      end
    end else if (state_reg == ST_WRITE && rx_take) begin
      if (is_coeff && !half_reg) begin
        hi_byte_reg <= rx_data;
        half_reg    <= 1'b1;
      end else begin
        half_reg <= 1'b0;
        left_reg <= left_reg - 1'b1;
        addr_reg <= addr_reg - 1'b1;
      end
    end else if (tx_step && is_coeff) begin
      if (half_reg) begin
        half_reg <= 1'b0;
        left_reg <= left_reg - 1'b1;
      end else if (walk_left) begin
        half_reg <= 1'b1;
      end
    end else if (tx_step && walk_left) begin
      left_reg <= left_reg - 1'b1;
      addr_reg <= addr_reg - 1'b1;
    end
  end

  // Transmit byte: ID first, then register bytes or word halves
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_data_reg  <= '0;
      tx_valid_reg <= 1'b0;
    end else if (cs_sync_reg) begin
      tx_valid_reg <= 1'b0;
    end else if (state_reg == ST_CMD && rx_take) begin
      tx_data_reg  <= ID_CODE;
      tx_valid_reg <= !rx_data[CMD_RW_BIT] && !cmd_bad;
    end else if (tx_step) begin
      if (is_coeff && half_reg) begin
        tx_data_reg <= rd_bytes[BYTE_W-1:0];
      end else if (is_coeff && walk_left) begin
        tx_data_reg <= rd_bytes[XFER_W-1:BYTE_W];
      end else if (!is_coeff && walk_left) begin
        tx_data_reg <= reg_value;
      end else begin
        tx_valid_reg <= 1'b0;
      end
    end
  end

  assign tx_data  = tx_data_reg;
  assign tx_valid = tx_valid_reg;

  // Register read strobe sits on the take that loads the byte
  assign reg_rd        = tx_step && !is_coeff && walk_left;
  assign reg_rd_global = is_global;
  assign reg_rd_addr   = addr_reg;

  // Register write strobe, registered; version writes do nothing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_wr_reg        <= 1'b0;
      reg_wr_global_reg <= 1'b0;
      reg_wr_addr_reg   <= '0;
      reg_wdata_reg     <= '0;
    end else begin
      reg_wr_reg <= state_reg == ST_WRITE && rx_take && !is_coeff
                    && !cs_sync_reg
                    && !(is_global && addr_reg == ADDR_VERSION);
      reg_wr_global_reg <= is_global;
      reg_wr_addr_reg   <= addr_reg;
      reg_wdata_reg     <= rx_data;
    end
  end

  assign reg_wr        = reg_wr_reg;
  assign reg_wr_global = reg_wr_global_reg;
  assign reg_wr_addr   = reg_wr_addr_reg;
  assign reg_wdata     = reg_wdata_reg;

  // Channel enable and clock select register, global so no channel needed
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ch_enable_reg <= CH_ENABLE_RESET;
    end else if (state_reg == ST_WRITE && rx_take && is_global
                 && addr_reg == ADDR_CH_ENABLE) begin
      ch_enable_reg <= rx_data;
    end
  end

  // Local writes fan out to every enabled channel
  assign chan_enable  = ce_bits;
  assign clock_select = ch_enable_reg[SEL_HI:0];
endmodule

// ==== host_command_port_chk.sv ====
/*
  Checker for the host command port pins.
  Assumes a bind onto host_command_port; one clock, reset async active low.
*/
`timescale 1ns/1ps
module host_command_port_chk #(
  parameter logic [codec_cmd_pkg::BYTE_W-1:0] ID_CODE = codec_cmd_pkg::ID_CODE_DEFAULT
) (
  input wire logic                                clock,
  input wire logic                                arst_n,
  input wire logic                                cs_n,
  input wire logic                                rx_valid,
  input wire logic [codec_cmd_pkg::BYTE_W-1:0]    rx_data,
  input wire logic                                tx_take,
  input wire logic [codec_cmd_pkg::BYTE_W-1:0]    tx_data,
  input wire logic                                tx_valid,
  input wire logic                                reg_wr,
  input wire logic                                reg_wr_global,
  input wire logic [codec_cmd_pkg::ADDR_W-1:0]    reg_wr_addr,
  input wire logic [codec_cmd_pkg::BYTE_W-1:0]    reg_wdata,
  input wire logic                                reg_rd,
  input wire logic [codec_cmd_pkg::CHANNELS-1:0]  chan_enable,
  input wire logic [codec_cmd_pkg::SEL_HI:0]      clock_select
);
  import codec_cmd_pkg::*;
  logic              cs_q1_reg, cs_q2_reg, got_cmd_reg, bad_reg, glob_reg, seen_reg;
  logic [ADDR_W-1:0] cmd_addr_reg, last_addr_reg;
  logic              cmd_take, ce_wr;
  // First byte of a frame, seen through our own copy of the cs sync
  assign cmd_take = rx_valid && !cs_q2_reg && !got_cmd_reg;
  assign ce_wr    = reg_wr && reg_wr_global && reg_wr_addr == ADDR_CH_ENABLE;
  // Two flops, like the design, so frame edges line up
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cs_q1_reg <= 1'b1;
      cs_q2_reg <= 1'b1;
    end else begin
      cs_q1_reg <= cs_n;
      cs_q2_reg <= cs_q1_reg;
    end
  end
  // Command kind and start address of the current frame
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      got_cmd_reg  <= 1'b0;
      bad_reg      <= 1'b0;
      glob_reg     <= 1'b0;
      cmd_addr_reg <= '0;
    end else if (cs_q2_reg) begin
      got_cmd_reg <= 1'b0;
      bad_reg     <= 1'b0;
    end else if (cmd_take) begin
      got_cmd_reg  <= 1'b1;
      bad_reg      <= rx_data[CMD_TYPE_HI:CMD_TYPE_LO] == TYPE_BAD;
      glob_reg     <= rx_data[CMD_TYPE_HI:CMD_TYPE_LO] == TYPE_GLOBAL;
      cmd_addr_reg <= rx_data[ADDR_W-1:0];
    end
  end
  // Last register written in this frame, for the walk
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      seen_reg      <= 1'b0;
      last_addr_reg <= '0;
    end else if (cs_q2_reg) begin
      seen_reg <= 1'b0;
    end else if (reg_wr) begin
      seen_reg      <= 1'b1;
      last_addr_reg <= reg_wr_addr;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence read_cmd_s;
    cmd_take && !rx_data[CMD_RW_BIT] && rx_data[CMD_TYPE_HI:CMD_TYPE_LO] != TYPE_BAD;
  endsequence
  sequence id_out_s;
    tx_valid && tx_data == ID_CODE;
  endsequence
  read_id_first_a: assert property (read_cmd_s |=> id_out_s)
    else $error("read reply did not open with the id byte");
  id_on_rise_a: assert property ($rose(tx_valid) |-> tx_data == ID_CODE)
    else $error("first reply byte is not the id byte");
  bad_type_quiet_a: assert property (bad_reg |-> !reg_wr && !tx_valid)
    else $error("refused command type still acted");
  wr_kind_a: assert property (reg_wr |-> reg_wr_global == glob_reg)
    else $error("register write kind differs from command type");
  walk_start_a: assert property (reg_wr && !seen_reg |-> reg_wr_addr == cmd_addr_reg)
    else $error("walk did not start at the command address");
  walk_down_a: assert property (reg_wr && seen_reg |-> reg_wr_addr == last_addr_reg - 5'h01)
    else $error("walk did not step down by one");
  version_no_wr_a: assert property (cmd_take && rx_data == 8'ha0 |=> !reg_wr [*6])
    else $error("version write produced a register write");
  ce_load_a: assert property (ce_wr |=> {chan_enable, clock_select} == $past(reg_wdata))
    else $error("channel enable did not take the written byte");
  ce_only_a: assert property ($changed(chan_enable) |-> ce_wr || $past(ce_wr))
    else $error("channel enable changed without a write");
  tx_stand_a: assert property (tx_valid && !tx_take && !cs_n && !cs_q1_reg && !cs_q2_reg
    |=> tx_valid && $stable(tx_data))
    else $error("reply byte moved before it was taken");
  rd_pulse_a: assert property (reg_rd |-> tx_take && tx_valid)
    else $error("register read outside a take");
endmodule

bind host_command_port host_command_port_chk #(.ID_CODE(ID_CODE)) chk (
  .clock(clock), .arst_n(arst_n), .cs_n(cs_n), .rx_valid(rx_valid), .rx_data(rx_data),
  .tx_take(tx_take), .tx_data(tx_data), .tx_valid(tx_valid), .reg_wr(reg_wr),
  .reg_wr_global(reg_wr_global), .reg_wr_addr(reg_wr_addr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .chan_enable(chan_enable), .clock_select(clock_select)
);

// ==== testbench.sv ====
/*
  Self-checking bench for host_command_port with a host byte model.
  Assumes 10 MHz; register reads are answered by a fixed address pattern.
*/
`timescale 1ns/1ps
module testbench;
  import codec_cmd_pkg::*;
  logic        clock, arst_n, cs_n, rx_valid, tx_take, tx_valid, reg_wr, reg_wr_global;
  logic        reg_rd, reg_rd_global;
  logic [7:0]  rx_data, tx_data, reg_wdata, reg_rdata, ce_now;
  logic [4:0]  reg_wr_addr, reg_rd_addr;
  logic [3:0]  chan_enable, clock_select;
  logic [13:0] wrq[$];
  logic [13:0] mem[4][40];
  int          errors, n_compared;
  host_command_port uut (
    .clock(clock), .arst_n(arst_n), .cs_n(cs_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_take(tx_take), .tx_data(tx_data), .tx_valid(tx_valid), .reg_wr(reg_wr),
    .reg_wr_global(reg_wr_global), .reg_wr_addr(reg_wr_addr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rd_global(reg_rd_global), .reg_rd_addr(reg_rd_addr),
    .reg_rdata(reg_rdata), .chan_enable(chan_enable), .clock_select(clock_select));
  host_byte_model host (
    .clock(clock), .cs_n(cs_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_take(tx_take), .tx_data(tx_data), .tx_valid(tx_valid));
  initial clock = 1'b0;
  always #50 clock = ~clock;
  // Register answer carries kind and address, so a wrong address shows
  assign reg_rdata = {reg_rd_global, 2'b10, reg_rd_addr};
  // Log every register write for later comparison
  always @(posedge clock) begin
    if (reg_wr === 1'b1) wrq.push_back({reg_wr_global, reg_wr_addr, reg_wdata});
  end
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_wr(input logic [13:0] exp);
    logic [13:0] got;
    got = 14'h3fff;
    if (wrq.size() > 0) got = wrq.pop_front();
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t write %h exp %h", $time, got, exp);
    end
  endtask
  task automatic expect_tx(input logic [7:0] exp, input int lag, input string what);
    logic [7:0] b;
    host.take(lag, b);
    cmp_byte(b, exp, what);
  endtask
  task automatic send_frame(input int n, input logic [7:0] b0, b1, b2);
    host.open_frame();
    host.send(b0);
    if (n > 1) host.send(b1);
    if (n > 2) host.send(b2);
    host.close_frame();
  endtask
  task automatic set_ce(input logic [7:0] d);
    send_frame(2, 8'ha5, d, 8'h00);
    ce_now = d;
    cmp_byte({4'h0, chan_enable}, {4'h0, d[7:4]}, "chan enable");
    cmp_byte({4'h0, clock_select}, {4'h0, d[3:0]}, "clock select");
  endtask
  task automatic coeff_write(input int blk, input int nw, input logic [7:0] salt, input bit cut);
    logic [15:0] w;
    host.open_frame();
    host.send(8'he0 | 8'(blk));
    for (int k = 7; k > 7 - nw; k--) begin
      w = {salt ^ 8'(blk * 8 + k), 3'(blk), 3'(k), 2'b11};
      host.send(w[15:8]);
      host.send(w[7:0]);
      // Tone words land only in enabled channels, others in every copy
      for (int c = 0; c < 4; c++)
        if (blk < 5 && (blk != 2 || k < 4 || ce_now[4 + c])) mem[c][blk * 8 + k] = w[15:2];
    end
    if (cut) host.send(8'h5a);
    host.close_frame();
  endtask
  task automatic coeff_read(input int blk);
    int c;
    logic [15:0] e;
    c = 0;
    for (int i = 3; i >= 0; i--)
      if (ce_now[4 + i]) c = i;
    host.open_frame();
    host.send(8'h60 | 8'(blk));
    expect_tx(ID_CODE_DEFAULT, 0, "coeff id");
    for (int k = 7; k >= 0; k--) begin
      e = {mem[c][blk * 8 + k], 2'b00};
      expect_tx(e[15:8], k % 3, "coeff hi");
      expect_tx(e[7:0], 0, "coeff lo");
    end
    host.close_frame();
  endtask
  task automatic test_reset();
    cmp_byte({4'h0, chan_enable}, 8'h00, "reset ce");
    cmp_byte({4'h0, clock_select}, 8'h02, "reset sel");
    cmp_byte({6'h0, tx_valid, reg_wr}, 8'h00, "reset idle");
  endtask
  task automatic test_registers();
    wrq.delete();
    host.open_frame();
    host.send(8'h20);
    expect_tx(ID_CODE_DEFAULT, 0, "gread id");
    expect_tx(VERSION_DEFAULT, 2, "gread ver");
    cmp_byte({7'h0, tx_valid}, 8'h00, "tx done");
    host.close_frame();
    send_frame(2, 8'ha0, 8'hff, 8'h00);
    send_frame(3, 8'ha3, 8'h11, 8'h22);
    set_ce(8'h12);
    send_frame(3, 8'h81, 8'h33, 8'h44);
    cmp_wr({1'b1, 5'h03, 8'h11});
    cmp_wr({1'b1, 5'h02, 8'h22});
    cmp_wr({1'b1, 5'h05, 8'h12});
    cmp_wr({1'b0, 5'h01, 8'h33});
    cmp_wr({1'b0, 5'h00, 8'h44});
    cmp_byte(8'(wrq.size()), 8'h00, "extra writes");
    host.open_frame();
    host.send(8'h01);
    expect_tx(ID_CODE_DEFAULT, 0, "lread id");
    expect_tx(8'h41, 1, "lread two");
    expect_tx(8'h40, 0, "lread one");
    host.close_frame();
  endtask
  task automatic test_coeff();
    set_ce(8'h32);
    for (int n = 0; n < 5; n++) coeff_write(n, 8, 8'(n * 37), 1'b0);
    for (int n = 0; n < 5; n++) coeff_read(n);
  endtask
  // Channel 2 tone words cut short; channel 1 copy must not move
  task automatic test_tone_abort();
    set_ce(8'h22);
    coeff_write(2, 2, 8'hc6, 1'b1);
    coeff_read(2);
    set_ce(8'h12);
    coeff_read(2);
  endtask
  task automatic test_refused();
    wrq.delete();
    send_frame(3, 8'hc1, 8'h55, 8'h66);
    host.open_frame();
    host.send(8'h45);
    repeat (6) @(negedge clock);
    cmp_byte({7'h0, tx_valid}, 8'h00, "bad read quiet");
    host.close_frame();
    coeff_write(5, 8, 8'h77, 1'b0);
    cmp_byte(8'(wrq.size()), 8'h00, "bad writes");
    coeff_read(0);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // The run needs about 900 cycles; 30000 leaves ample margin
  initial begin
    #3000000;
    errors++;
    report_and_stop();
  end
  initial begin
    arst_n = 1'b0;
    errors = 0;
    n_compared = 0;
    ce_now = CH_ENABLE_RESET;
    repeat (3) @(negedge clock);
    test_reset();
    arst_n = 1'b1;
    test_registers();
    test_coeff();
    test_tone_abort();
    test_refused();
    // Second reset: registers return, coefficient memory stays
    arst_n = 1'b0;
    ce_now = CH_ENABLE_RESET;
    @(negedge clock);
    test_reset();
    arst_n = 1'b1;
    coeff_read(0);
    report_and_stop();
  end
endmodule
